// ### rtl/qsrm_pkg.sv
// constants and types shared by the quad serial read master
package qsrm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS      = 40000; // 25 MHz system clock
  localparam int SCLK_MIN_PERIOD_PS = 12500; // fastest legal serial clock
  localparam int SCLK_MIN_CYC_RAW   = (SCLK_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_MIN_CYC       = (SCLK_MIN_CYC_RAW < 1) ? 1 : SCLK_MIN_CYC_RAW;
  localparam int SCLK_GEN_MIN_CYC   = 2;     // a flop-made clock needs two cycles a period

  // ****************************************************************
  // frame limits and counts
  // ****************************************************************
  localparam int WORD_LEN_MAX  = 128;
  localparam int WORD_CNT_MAX  = 4096;
  localparam int DELAY_MAX     = 3;
  localparam int LEAD_PERIODS  = 1;        // driver enable ahead of select
  localparam int TRAIL_PERIODS = 2;        // select held after last falling edge
  localparam int SYNC_LAT      = 3;        // falling edge to captured data

  // ****************************************************************
  // lane selection codes
  // ****************************************************************
  localparam logic [1:0] LANES_ONE  = 2'h0;
  localparam logic [1:0] LANES_TWO  = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h2;

  // ****************************************************************
  // reset values of the pins
  // ****************************************************************
  localparam logic       CS_N_RST = 1'h1;
  localparam logic       SCLK_RST = 1'h0;
  localparam logic [3:0] DQ_RST   = 4'h0;
  localparam logic [3:0] OE_RST   = 4'h0;

  // ****************************************************************
  // sequencer states, gray along the frame
  // ****************************************************************
  typedef enum logic [2:0] {
    QSRM_IDLE  = 3'h0,
    QSRM_LEAD  = 3'h1,
    QSRM_DELAY = 3'h3,
    QSRM_SHIFT = 3'h2,
    QSRM_TRAIL = 3'h6
  } qsrm_state_type;

endpackage

// ### rtl/qsrm_core.sv
// quad serial read master: sequencer, clock divider, pin sync and word assembly
module qsrm_core
  import qsrm_pkg::*;
#(
  parameter int DIV_W  = 8,
  parameter int WLEN_W = 7,
  parameter int WCNT_W = 12
) (
  // clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // frame request and configuration
  input  wire logic                    start_i,
  input  wire logic [1:0]              lanes_i,
  input  wire logic [WLEN_W-1:0]       word_len_m1_i,
  input  wire logic [WCNT_W-1:0]       word_cnt_m1_i,
  input  wire logic [1:0]              select_to_clock_delay_field_i,
  input  wire logic [DIV_W-1:0]        serial_clock_divide_factor_i,
  input  wire logic [WORD_LEN_MAX-1:0] tx_word_i,
  input  wire logic                    word_irq_en_i,
  input  wire logic                    frame_irq_en_i,
  // serial pins
  output logic                         sclk_o,
  output logic                         cs_n_o,
  input  wire logic [3:0]              dq_i,
  output logic [3:0]                   dq_o,
  output logic [3:0]                   dq_oe_o,
  // results and status
  output logic [WORD_LEN_MAX-1:0]      rx_word_o,
  output logic                         word_valid_o,
  output logic                         frame_done_o,
  output logic                         irq_o,
  output logic                         busy_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if ((2 ** WLEN_W) != WORD_LEN_MAX) begin : g_chk_wlen
    $error("word length field must span exactly 1 to 128");
  end
  if ((2 ** WCNT_W) != WORD_CNT_MAX) begin : g_chk_wcnt
    $error("word count field must span exactly 1 to 4096");
  end
  if (SCLK_MIN_CYC > SCLK_GEN_MIN_CYC || DIV_W < 1) begin : g_chk_div
    $error("divider cannot honour the minimum serial clock period");
  end

  // shift amount for the lane count: bits per falling edge is 1 << shift
  function automatic logic [1:0] lane_shift(input logic [1:0] lanes);
    lane_shift = (lanes == LANES_ONE) ? 2'h0 : (lanes == LANES_TWO) ? 2'h1 : 2'h2;
  endfunction

  // ****************************************************************
  // input synchroniser, three stages with agreement filter
  // ****************************************************************
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] dq_filt;
  logic [3:0] next_dq_filt;

  // a bit moves only when stages two and three agree
  always_comb begin
    next_dq_filt = (dq_filt & (sync2 ^ sync3)) | (sync2 & ~(sync2 ^ sync3));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1   <= 4'h0;
      sync2   <= 4'h0;
      sync3   <= 4'h0;
      dq_filt <= 4'h0;
    end else if (ce_i) begin
      sync1   <= dq_i;
      sync2   <= sync1;
      sync3   <= sync2;
      dq_filt <= next_dq_filt;
    end
  end

  // ****************************************************************
  // sequencer, clock generator and pin drivers
  // ****************************************************************
  qsrm_state_type           state,     next_state;
  logic [DIV_W:0]           ph,        next_ph;
  logic [DIV_W:0]           per_m1,    next_per_m1;
  logic [DIV_W:0]           low_len,   next_low_len;
  logic [1:0]               lsh,       next_lsh;
  logic [WLEN_W-1:0]        wlen,      next_wlen;
  logic [WLEN_W-1:0]        bit_left,  next_bit_left;
  logic [WCNT_W-1:0]        word_left, next_word_left;
  logic [1:0]               dly_left,  next_dly_left;
  logic [1:0]               dly_cfg,   next_dly_cfg;
  logic                     trl_left,  next_trl_left;
  logic [WORD_LEN_MAX-1:0]  tx_sh,     next_tx_sh;
  logic                     next_sclk;
  logic                     next_cs_n;
  logic [3:0]               next_dq;
  logic [3:0]               next_oe;
  logic                     next_busy;
  logic                     per_end;
  logic                     fall_evt;
  logic                     word_end;
  logic                     frame_end;
  logic [DIV_W:0]           div_ext;

  assign per_end = (ph == per_m1);
  assign fall_evt = (state == QSRM_SHIFT) && per_end;

  always_comb begin
    div_ext        = {1'b0, serial_clock_divide_factor_i};
    next_state     = state;
    next_ph        = per_end ? '0 : (DIV_W+1)'(1) + ph;
    next_per_m1    = per_m1;
    next_low_len   = low_len;
    next_lsh       = lsh;
    next_wlen      = wlen;
    next_bit_left  = bit_left;
    next_word_left = word_left;
    next_dly_left  = dly_left;
    next_dly_cfg   = dly_cfg;
    next_trl_left  = trl_left;
    next_tx_sh     = tx_sh;
    next_cs_n      = cs_n_o;
    next_oe        = dq_oe_o;
    next_busy      = busy_o;
    word_end       = 1'b0;
    frame_end      = 1'b0;
    unique case (state)
      QSRM_IDLE: begin
        next_ph = '0;
        if (start_i) begin
          // period D+1 cycles, high part (D+1)/2 rounded down; D of 0 runs at two cycles
          // zero or odd D keeps both halves equal, even D gives the short high part
          next_per_m1  = (div_ext == '0) ? (DIV_W+1)'(1) : div_ext;
          next_low_len = (div_ext == '0) ? (DIV_W+1)'(1)
                                          : div_ext + (DIV_W+1)'(1) - ((div_ext + (DIV_W+1)'(1)) >> 1);
          next_lsh       = lane_shift(lanes_i);
          next_wlen      = word_len_m1_i;
          next_bit_left  = word_len_m1_i >> lane_shift(lanes_i);
          next_word_left = word_cnt_m1_i;
          next_dly_cfg   = select_to_clock_delay_field_i;
          next_tx_sh     = tx_word_i;
          next_oe        = (lanes_i == LANES_ONE) ? 4'h1 : 4'h0;
          next_busy      = 1'b1;
          next_state     = QSRM_LEAD;
        end
      end
      QSRM_LEAD: begin
        if (per_end) begin
          next_cs_n     = 1'b0;
          next_dly_left = dly_cfg;
          next_state    = (dly_cfg == 2'h0) ? QSRM_SHIFT : QSRM_DELAY;
        end
      end
      QSRM_DELAY: begin
        // clock held low for the extra select-to-clock periods
        if (per_end) begin
          next_dly_left = dly_left - 2'h1;
          if (dly_left == 2'h1) begin
            next_state = QSRM_SHIFT;
          end
        end
      end
      QSRM_SHIFT: begin
        if (fall_evt) begin
          next_tx_sh = {tx_sh[WORD_LEN_MAX-2:0], 1'b0};
          if (bit_left == '0) begin
            word_end      = 1'b1;
            next_bit_left = wlen >> lsh;
            if (word_left == '0) begin
              frame_end     = 1'b1;
              next_trl_left = 1'b1;
              next_state    = QSRM_TRAIL;
            end else begin
              next_word_left = word_left - WCNT_W'(1);
            end
          end else begin
            next_bit_left = bit_left - WLEN_W'(1);
          end
        end
      end
      QSRM_TRAIL: begin
        // two full periods after the last fall, then release select
        if (per_end) begin
          next_trl_left = 1'b0;
          if (!trl_left) begin
            next_cs_n  = 1'b1;
            next_oe    = 4'h0;
            next_busy  = 1'b0;
            next_state = QSRM_IDLE;
          end
        end
      end
      default: begin
        next_state = QSRM_IDLE;
      end
    endcase
    // mode zero: low half first, rising mid-period, falling at period end
    next_sclk = (next_state == QSRM_SHIFT) && (state == QSRM_SHIFT || per_end)
                && (next_ph >= low_len);
    next_dq   = {3'h0, next_tx_sh[WORD_LEN_MAX-1] & next_oe[0]};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= QSRM_IDLE;
      ph        <= '0;
      per_m1    <= (DIV_W+1)'(1);
      low_len   <= (DIV_W+1)'(1);
      lsh       <= 2'h0;
      wlen      <= '0;
      bit_left  <= '0;
      word_left <= '0;
      dly_left  <= 2'h0;
      dly_cfg   <= 2'h0;
      trl_left  <= 1'b0;
      tx_sh     <= '0;
      sclk_o    <= SCLK_RST;
      cs_n_o    <= CS_N_RST;
      dq_o      <= DQ_RST;
      dq_oe_o   <= OE_RST;
      busy_o    <= 1'b0;
    end else if (ce_i) begin
      state     <= next_state;
      ph        <= next_ph;
      per_m1    <= next_per_m1;
      low_len   <= next_low_len;
      lsh       <= next_lsh;
      wlen      <= next_wlen;
      bit_left  <= next_bit_left;
      word_left <= next_word_left;
      dly_left  <= next_dly_left;
      dly_cfg   <= next_dly_cfg;
      trl_left  <= next_trl_left;
      tx_sh     <= next_tx_sh;
      sclk_o    <= next_sclk;
      cs_n_o    <= next_cs_n;
      dq_o      <= next_dq;
      dq_oe_o   <= next_oe;
      busy_o    <= next_busy;
    end
  end

  // ****************************************************************
  // receive assembly, delayed to line up with the synchroniser
  // ****************************************************************
  logic [SYNC_LAT-1:0]     fall_dly,  next_fall_dly;
  logic [SYNC_LAT-1:0]     wend_dly,  next_wend_dly;
  logic [SYNC_LAT-1:0]     fend_dly,  next_fend_dly;
  logic [WORD_LEN_MAX-1:0] rx_sh,     next_rx_sh;
  logic [WORD_LEN_MAX-1:0] next_rx_word;
  logic                    next_word_valid;
  logic                    next_frame_done;
  logic                    next_irq;
  logic [WORD_LEN_MAX-1:0] shifted;

  always_comb begin
    next_fall_dly   = {fall_dly[SYNC_LAT-2:0], fall_evt};
    next_wend_dly   = {wend_dly[SYNC_LAT-2:0], word_end};
    next_fend_dly   = {fend_dly[SYNC_LAT-2:0], frame_end};
    next_rx_sh      = rx_sh;
    next_rx_word    = rx_word_o;
    next_word_valid = 1'b0;
    next_frame_done = 1'b0;
    next_irq        = 1'b0;
    unique case (lsh)
      2'h0:    shifted = {rx_sh[WORD_LEN_MAX-2:0], dq_filt[1]};
      2'h1:    shifted = {rx_sh[WORD_LEN_MAX-3:0], dq_filt[1:0]};
      default: shifted = {rx_sh[WORD_LEN_MAX-5:0], dq_filt[3:0]};
    endcase
    // bits caught at the falling edge, three cycles late
    if (fall_dly[SYNC_LAT-1]) begin
      next_rx_sh = shifted;
      if (wend_dly[SYNC_LAT-1]) begin
        next_rx_sh      = '0;
        next_rx_word    = shifted;
        next_word_valid = 1'b1;
        next_frame_done = fend_dly[SYNC_LAT-1];
        next_irq        = word_irq_en_i | (frame_irq_en_i & fend_dly[SYNC_LAT-1]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fall_dly     <= '0;
      wend_dly     <= '0;
      fend_dly     <= '0;
      rx_sh        <= '0;
      rx_word_o    <= '0;
      word_valid_o <= 1'b0;
      frame_done_o <= 1'b0;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      fall_dly     <= next_fall_dly;
      wend_dly     <= next_wend_dly;
      fend_dly     <= next_fend_dly;
      rx_sh        <= next_rx_sh;
      rx_word_o    <= next_rx_word;
      word_valid_o <= next_word_valid;
      frame_done_o <= next_frame_done;
      irq_o        <= next_irq;
    end
  end

endmodule // qsrm_core

// ### bench/qsrm_core_asserts.sv
// pin timing checker for the quad serial read master
module qsrm_core_asserts
  import qsrm_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // configuration
  input wire logic [1:0]       select_to_clock_delay_field_i,
  input wire logic [DIV_W-1:0] serial_clock_divide_factor_i,
  input wire logic             word_irq_en_i,
  input wire logic             frame_irq_en_i,
  // pins and status
  input wire logic             sclk_o,
  input wire logic             cs_n_o,
  input wire logic [3:0]       dq_o,
  input wire logic [3:0]       dq_oe_o,
  input wire logic             word_valid_o,
  input wire logic             frame_done_o,
  input wire logic             irq_o,
  input wire logic             busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        sclk_q, cs_q, oe_q, seen;
  logic [15:0] n_s, n_c, n_f, n_o, per, hi;
  logic        s_fall;
  // serial period and high part in clock cycles
  assign per = (serial_clock_divide_factor_i == '0) ? 16'h2 :
               16'(serial_clock_divide_factor_i) + 16'h1;
  assign hi = per >> 1;
  assign s_fall = sclk_q & ~sclk_o;
  // cycle counters since clock change, select fall, last fall, driver enable
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk_o;
    cs_q <= cs_n_o;
    oe_q <= dq_oe_o[0];
    n_s <= (sclk_o != sclk_q) ? 16'h1 : n_s + 16'h1;
    n_c <= (cs_q && !cs_n_o) ? 16'h1 : n_c + 16'h1;
    n_f <= s_fall ? 16'h1 : n_f + 16'h1;
    n_o <= (dq_oe_o[0] && !oe_q) ? 16'h1 : n_o + 16'h1;
    seen <= cs_n_o ? 1'b0 : (seen | s_fall);
  end
  property p_idle; !busy_o |-> cs_n_o && !sclk_o; endproperty
  a_idle: assert property (p_idle) else $error("clock or select active while idle");
  property p_master; !cs_n_o |-> busy_o && dq_oe_o[3:1] == 3'h0; endproperty
  a_master: assert property (p_master) else $error("select without frame");
  property p_first;
    s_fall && !seen |-> n_c == per * (16'(select_to_clock_delay_field_i) + 16'h1);
  endproperty
  a_first: assert property (p_first) else $error("select lead wrong");
  property p_trail; $rose(cs_n_o) |-> n_f == 16'h2 * per; endproperty
  a_trail: assert property (p_trail) else $error("select trail wrong");
  property p_high; s_fall |-> n_s == hi; endproperty
  a_high: assert property (p_high) else $error("clock high part wrong");
  property p_low; $rose(sclk_o) && seen |-> n_s == per - hi; endproperty
  a_low: assert property (p_low) else $error("clock low part wrong");
  property p_lead; $fell(cs_n_o) && dq_oe_o[0] |-> n_o == per; endproperty
  a_lead: assert property (p_lead) else $error("driver enable lead wrong");
  property p_rel; $rose(cs_n_o) |-> dq_oe_o == 4'h0 && !busy_o; endproperty
  a_rel: assert property (p_rel) else $error("driver not released");
  property p_dout;
    $changed(dq_o[0]) |-> s_fall || $rose(dq_oe_o[0]) || !dq_oe_o[0];
  endproperty
  a_dout: assert property (p_dout) else $error("data out off falling edge");
  property p_cap; word_valid_o |-> $past(s_fall, 3); endproperty
  a_cap: assert property (p_cap) else $error("word not tied to fall");
  property p_irq;
    word_valid_o |-> irq_o == (word_irq_en_i || (frame_done_o && frame_irq_en_i));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong");
  property p_pulse; irq_o || frame_done_o |-> word_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse without word");
endmodule // qsrm_core_asserts

bind qsrm_core qsrm_core_asserts #(.DIV_W(DIV_W)) qsrm_core_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i),
  .select_to_clock_delay_field_i(select_to_clock_delay_field_i),
  .serial_clock_divide_factor_i(serial_clock_divide_factor_i),
  .word_irq_en_i(word_irq_en_i), .frame_irq_en_i(frame_irq_en_i),
  .sclk_o(sclk_o), .cs_n_o(cs_n_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .word_valid_o(word_valid_o), .frame_done_o(frame_done_o),
  .irq_o(irq_o), .busy_o(busy_o)
);

// ### bench/qsrm_flash_model.sv
// behavioural serial flash answering read frames
module qsrm_flash_model (
  // pins seen from the far side
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  output logic [3:0]      dq_o,
  // scenario control and capture
  input  wire logic       slow_i,
  input  wire logic [3:0] first_nib_i,
  output logic [127:0]    mosi_cap_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] nib;
  initial begin
    dq_o = 4'h5;
    nib = 4'h0;
    mosi_cap_o = '0;
  end
  // first nibble ready once select goes active
  always @(negedge cs_n_i) begin
    nib = first_nib_i;
    mosi_cap_o = '0;
    #1 dq_o = nib;
  end
  // next nibble launched on each falling clock edge, promptly or late
  always @(negedge sclk_i) begin
    if (!cs_n_i) begin
      nib = nib + 4'h1;
      #(slow_i ? 20 : 1) dq_o = nib;
    end
  end
  // outgoing bits taken on rising edges, mode zero
  always @(posedge sclk_i) begin
    if (!cs_n_i) mosi_cap_o = {mosi_cap_o[126:0], mosi_i};
  end
  // released lines no longer hold the last value
  always @(posedge cs_n_i) #1 dq_o = ~dq_o;
endmodule // qsrm_flash_model

// ### bench/tb_qsrm_core.sv
// self-checking bench for the quad serial read master
module tb_qsrm_core
  import qsrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk_i, rst_i, start_i, wirq, firq, slow;
  logic [1:0]   lanes, dd;
  logic [6:0]   lm1;
  logic [11:0]  cm1;
  logic [7:0]   dv;
  logic [3:0]   first_nib, fdq, dq_i, dq_o, dq_oe_o;
  logic         sclk_o, cs_n_o, word_valid_o, frame_done_o, irq_o, busy_o;
  logic [127:0] tx, rx_word_o, cap;
  int           n_mismatch, n_compared, cyc;

  qsrm_core qsrm_core_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .start_i(start_i),
    .lanes_i(lanes), .word_len_m1_i(lm1), .word_cnt_m1_i(cm1),
    .select_to_clock_delay_field_i(dd), .serial_clock_divide_factor_i(dv),
    .tx_word_i(tx), .word_irq_en_i(wirq), .frame_irq_en_i(firq),
    .sclk_o(sclk_o), .cs_n_o(cs_n_o), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .rx_word_o(rx_word_o), .word_valid_o(word_valid_o),
    .frame_done_o(frame_done_o), .irq_o(irq_o), .busy_o(busy_o)
  );
  qsrm_flash_model qsrm_flash_model_i (
    .sclk_i(sclk_o), .cs_n_i(cs_n_o), .mosi_i(dq_o[0]), .dq_o(fdq),
    .slow_i(slow), .first_nib_i(first_nib), .mosi_cap_o(cap)
  );
  // data line 0 is shared with the outgoing driver
  assign dq_i = {fdq[3:1], dq_oe_o[0] ? dq_o[0] : fdq[0]};

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one frame: start, refused restart, every word and pulse compared
  task automatic run(input logic [1:0] ln, input logic [6:0] l, input logic [11:0] c,
                     input logic [1:0] d, input logic [7:0] v, input logic w, f, s);
    int           k, i, fl, nf, wd, nt;
    logic [127:0] ex;
    logic [3:0]   nb;
    wd = (ln == 2'h0) ? 1 : (ln == 2'h1) ? 2 : 4;
    nf = (int'(l) + wd) / wd;
    nt = (int'(c) + 1) * nf;
    nb = first_nib;
    lanes = ln; lm1 = l; cm1 = c; dd = d; dv = v; wirq = w; firq = f; slow = s;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    check(busy_o, 1'b1);
    for (k = 0; k <= int'(c); k++) begin
      ex = '0;
      for (fl = 0; fl < nf; fl++) begin
        ex = (ex << wd) | 128'(ln == 2'h0 ? {3'h0, nb[1]} :
                               ln == 2'h1 ? {2'h0, nb[1:0]} : nb);
        nb = nb + 4'h1;
      end
      i = 0;
      while (word_valid_o !== 1'b1 && i < 2000) begin
        start_i = (i == 4);
        i++;
        @(negedge clk_i);
      end
      start_i = 1'b0;
      check(rx_word_o, ex);
      check(frame_done_o, k == int'(c));
      check(irq_o, w | (f & (k == int'(c))));
      @(negedge clk_i);
    end
    i = 0;
    while (busy_o !== 1'b0 && i < 100) begin
      i++;
      @(negedge clk_i);
    end
    repeat (3) @(negedge clk_i);
    check(busy_o, 1'b0);
    check(cs_n_o, 1'b1);
    if (ln == 2'h0 && nt <= 128) check(cap, tx >> (128 - nt));
    $display("frame lanes=%0d words=%0d done", ln, int'(c) + 1);
  endtask

  // cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    {rst_i, start_i, wirq, firq, slow} = 5'h10;
    lanes = 2'h0; lm1 = 7'h0; cm1 = 12'h0; dd = 2'h0; dv = 8'h1;
    tx = {4{32'hC3A5_0F96}};
    first_nib = 4'h6;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    check(cs_n_o, 1'b1);
    check(sclk_o, 1'b0);
    check(dq_oe_o, 4'h0);
    @(negedge clk_i);
    run(LANES_ONE, 7'h1, 12'h0, 2'h0, 8'h1, 1'b1, 1'b0, 1'b0);
    run(LANES_TWO, 7'h6, 12'h2, 2'h3, 8'h0, 1'b0, 1'b1, 1'b0);
    run(LANES_FOUR, 7'h7F, 12'h1, 2'h1, 8'h2, 1'b1, 1'b1, 1'b1);
    run(2'h3, 7'h0, 12'h3, 2'h2, 8'h3, 1'b0, 1'b0, 1'b1);
    run(LANES_ONE, 7'h7F, 12'h0, 2'h3, 8'h4, 1'b0, 1'b1, 1'b1);
    run(LANES_FOUR, 7'h0, 12'hFFF, 2'h0, 8'h0, 1'b0, 1'b1, 1'b0);
    finish_test();
  end
endmodule // tb_qsrm_core
